/* File: logic/sxda_regs.vh */
// constants for the stretched external data access block
`ifndef SXDA_REGS_VH
`define SXDA_REGS_VH
// ----------------------------------------------------------------
// register addresses on the core's special register port
// ----------------------------------------------------------------
`define SXDA_PTR_SEL_ADDR    8'h86
`define SXDA_CLK_CTRL_ADDR   8'h8e
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SXDA_STRETCH_MSB     2
`define SXDA_STRETCH_LSB     0
`define SXDA_PTR_SEL_BIT     0
`define SXDA_STRETCH_RST     3'h1
`define SXDA_PTR_SEL_RST     1'h0
// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SXDA_CLKS_PER_MC     6'h04
`define SXDA_STROBE_MIN      6'h02
`define SXDA_STROBE_PER_UNIT 6'h04
`endif

/* File: logic/sxda_data_pointer_zero.v */
// two data pointers and the pointer select bit
`timescale 1ns/1ps
`default_nettype none
`include "sxda_regs.vh"
module sxda_data_pointer_zero (
   input  wire        ref_clk,      // core clock
   input  wire        sys_rst,      // synchronous reset, active high
   input  wire        sel_wr,       // write pointer select register
   input  wire [7:0]  sel_wdata,    // data for the select register
   input  wire        sel_inc,      // increment select register
   input  wire        sel_dec,      // decrement select register
   input  wire        ptr_load,     // load selected pointer
   input  wire [15:0] ptr_load_data,// value to load
   input  wire        ptr_inc,      // increment selected pointer
   output wire        ptr_sel,      // current pointer select
   output wire [15:0] ptr_value     // selected pointer value
);
   reg        sel_reg;
   reg [15:0] ptr0_reg;
   reg [15:0] ptr1_reg;
   // ----------------------------------------------------------------
   // select bit: only the lsb exists, inc or dec alone flips it, both at once leave it
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         sel_reg <= `SXDA_PTR_SEL_RST;
      end else if (sel_wr) begin
         sel_reg <= sel_wdata[`SXDA_PTR_SEL_BIT];
      end else if (sel_inc ^ sel_dec) begin
         sel_reg <= ~sel_reg;
      end
   end
   // ----------------------------------------------------------------
   // pointers: loads and increments go to the selected one only
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ptr0_reg <= 16'h0000;
         ptr1_reg <= 16'h0000;
      end else if (ptr_load) begin
         if (sel_reg) begin
            ptr1_reg <= ptr_load_data;
         end else begin
            ptr0_reg <= ptr_load_data;
         end
      end else if (ptr_inc) begin
         if (sel_reg) begin
            ptr1_reg <= ptr1_reg + 16'h0001;
         end else begin
            ptr0_reg <= ptr0_reg + 16'h0001;
         end
      end
   end
   assign ptr_sel   = sel_reg;
   assign ptr_value = sel_reg ? ptr1_reg : ptr0_reg;
endmodule
`default_nettype wire

/* File: logic/sxda_top.v */
// external move sequencer with access stretch and dual pointers
`timescale 1ns/1ps
`default_nettype none
`include "sxda_regs.vh"
module sxda_top (
   input  wire        ref_clk,       // core clock, 20 MHz
   input  wire        sys_rst,       // synchronous reset, active high
   input  wire        sfr_wr,        // core register write strobe
   input  wire [7:0]  sfr_addr,      // core register address
   input  wire [7:0]  sfr_wdata,     // core register write data
   output reg  [7:0]  sfr_rdata_reg, // core register read data
   input  wire        sel_inc,       // increment pointer select
   input  wire        sel_dec,       // decrement pointer select
   input  wire        ptr_load,      // load selected pointer
   input  wire [15:0] ptr_load_data, // pointer load value
   input  wire        ptr_inc,       // increment selected pointer
   input  wire        external_move_instruction_start,    // external move begins, one cycle
   input  wire        external_move_instruction_use_ptr,  // 1: pointer address, 0: ri/port 2
   input  wire        external_move_instruction_write,    // 1: write, 0: read
   input  wire [7:0]  ri_value,      // selected working register
   input  wire [7:0]  p2_value,      // port 2 register
   input  wire [7:0]  external_move_instruction_wdata,    // byte to write
   input  wire [7:0]  ext_data_in,   // data bus pin input
   output reg  [15:0] ext_addr_reg,  // external address
   output reg  [7:0]  ext_data_out_reg, // data bus pin output
   output reg         ext_data_oe_reg,  // data bus output enable
   output reg         ext_rd_n_reg,  // read strobe, active low
   output reg         ext_wr_n_reg,  // write strobe, active low
   output reg         cpu_hold_reg,  // core held while move runs
   output reg         external_move_instruction_done_reg, // one-cycle end of move
   output reg  [7:0]  external_move_instruction_rdata_reg // byte read
);
   // ----------------------------------------------------------------
   // states and helpers
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_FETCH = 3'b010;
   localparam [2:0] ST_ACC   = 3'b100;

   // strobe length in clocks for a stretch value
   function [5:0] strobe_len;
      input [2:0] s;
      begin
         if (s == 3'h0) begin
            strobe_len = `SXDA_STROBE_MIN;
         end else begin
            strobe_len = {3'h0, s} * `SXDA_STROBE_PER_UNIT;
         end
      end
   endfunction

   // strobe sits inside the access cycles, starting at their second or
   // third clock, so the address settles before and holds after it
   function in_strobe;
      input [5:0] c;
      input [2:0] s;
      reg   [5:0] first;
      begin
         first = (s == 3'h0) ? 6'h01 : 6'h02;
         in_strobe = (c >= first) && (c < first + strobe_len(s));
      end
   endfunction

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [2:0] stretch_reg;
   reg [2:0] run_stretch_reg;
   reg [5:0] cnt_reg;
   reg [5:0] cnt_next;
   reg [5:0] acc_last;
   reg       strobe_next;
   reg [7:0] din_meta_reg;
   reg [7:0] din_sync_reg;

   wire        ptr_sel;
   wire [15:0] ptr_value;
   wire        sel_wr = sfr_wr && (sfr_addr == `SXDA_PTR_SEL_ADDR);
   wire        ckc_wr = sfr_wr && (sfr_addr == `SXDA_CLK_CTRL_ADDR);

   // ----------------------------------------------------------------
   // pointer bank
   // ----------------------------------------------------------------
   sxda_data_pointer_zero u_data_pointer_zero (
      .ref_clk       (ref_clk),
      .sys_rst       (sys_rst),
      .sel_wr        (sel_wr),
      .sel_wdata     (sfr_wdata),
      .sel_inc       (sel_inc),
      .sel_dec       (sel_dec),
      .ptr_load      (ptr_load),
      .ptr_load_data (ptr_load_data),
      .ptr_inc       (ptr_inc),
      .ptr_sel       (ptr_sel),
      .ptr_value     (ptr_value)
   );

   // ----------------------------------------------------------------
   // clock control register and register read port
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         stretch_reg <= `SXDA_STRETCH_RST;
      end else if (ckc_wr) begin
         stretch_reg <= sfr_wdata[`SXDA_STRETCH_MSB:`SXDA_STRETCH_LSB];
      end
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         sfr_rdata_reg <= 8'h00;
      end else if (sfr_addr == `SXDA_PTR_SEL_ADDR) begin
         sfr_rdata_reg <= {7'h00, ptr_sel};
      end else if (sfr_addr == `SXDA_CLK_CTRL_ADDR) begin
         sfr_rdata_reg <= {5'h00, stretch_reg};
      end else begin
         sfr_rdata_reg <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // data pin synchroniser
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         din_meta_reg <= 8'h00;
         din_sync_reg <= 8'h00;
      end else begin
         din_meta_reg <= ext_data_in;
         din_sync_reg <= din_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // sequencer: fetch cycle, then stretch+1 access cycles
   // ----------------------------------------------------------------
   always @* begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      acc_last    = {1'b0, run_stretch_reg, 2'b11}; // 4*(s+1)-1
      strobe_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (external_move_instruction_start) begin
               state_next = ST_FETCH;
               cnt_next   = 6'h00;
            end
         end
         ST_FETCH: begin
            if (cnt_reg == `SXDA_CLKS_PER_MC - 6'h01) begin
               state_next = ST_ACC;
               cnt_next   = 6'h00;
               strobe_next = in_strobe(6'h00, run_stretch_reg);
            end else begin
               cnt_next = cnt_reg + 6'h01;
            end
         end
         ST_ACC: begin
            if (cnt_reg == acc_last) begin
               state_next = ST_IDLE;
               cnt_next   = 6'h00;
            end else begin
               cnt_next    = cnt_reg + 6'h01;
               strobe_next = in_strobe(cnt_next, run_stretch_reg);
            end
         end
         default: begin
            state_next = ST_IDLE;
            cnt_next   = 6'h00;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         state_reg       <= ST_IDLE;
         cnt_reg         <= 6'h00;
         run_stretch_reg <= `SXDA_STRETCH_RST;
         cpu_hold_reg    <= 1'b0;
         external_move_instruction_done_reg   <= 1'b0;
      end else begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         // hold covers only external moves; other instructions never start us
         cpu_hold_reg  <= (state_next != ST_IDLE);
         external_move_instruction_done_reg <= (state_reg == ST_ACC) && (state_next == ST_IDLE);
         if (state_reg == ST_IDLE && external_move_instruction_start) begin
            // a stretch change mid-move takes effect on the next move only
            run_stretch_reg <= stretch_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin drivers: address latched at start, strobes only in access
   // ----------------------------------------------------------------
   reg op_write_reg;
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         ext_addr_reg     <= 16'h0000;
         ext_data_out_reg <= 8'h00;
         ext_data_oe_reg  <= 1'b0;
         ext_rd_n_reg     <= 1'b1;
         ext_wr_n_reg     <= 1'b1;
         op_write_reg     <= 1'b0;
         external_move_instruction_rdata_reg   <= 8'h00;
      end else begin
         if (state_reg == ST_IDLE && external_move_instruction_start) begin
            op_write_reg     <= external_move_instruction_write;
            ext_data_out_reg <= external_move_instruction_wdata;
            if (external_move_instruction_use_ptr) begin
               ext_addr_reg <= ptr_value;
            end else begin
               ext_addr_reg <= {p2_value, ri_value};
            end
         end
         // address register is untouched from fetch to end, so stable under strobe
         ext_rd_n_reg    <= ~(strobe_next && !op_write_reg);
         ext_wr_n_reg    <= ~(strobe_next && op_write_reg);
         ext_data_oe_reg <= (state_next == ST_ACC) && op_write_reg;
         // taken as the move ends; the two-flop lag makes this the pin value
         // of the last strobe clock, or the first one at stretch 0, so slow
         // parts want stretch >= 1
         if ((state_reg == ST_ACC) && (state_next == ST_IDLE) && !op_write_reg) begin
            external_move_instruction_rdata_reg <= din_sync_reg;
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/sxda_monitor.sv */
// timing assertions on the external move sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sxda_monitor (
   input wire logic        ref_clk,         // core clock
   input wire logic        sys_rst,         // sync reset
   input wire logic        sfr_wr,          // register write
   input wire logic [7:0]  sfr_addr,        // register address
   input wire logic [7:0]  sfr_wdata,       // register data
   input wire logic [7:0]  sfr_rdata_reg,   // register read data
   input wire logic        external_move_instruction_start,      // move start
   input wire logic        external_move_instruction_use_ptr,    // pointer address
   input wire logic [7:0]  ri_value,        // low address byte
   input wire logic [7:0]  p2_value,        // high address byte
   input wire logic [15:0] ext_addr_reg,    // external address
   input wire logic        ext_rd_n_reg,    // read strobe
   input wire logic        ext_wr_n_reg,    // write strobe
   input wire logic        ext_data_oe_reg, // data bus drive enable
   input wire logic        cpu_hold_reg,    // core held
   input wire logic        external_move_instruction_done_reg    // move done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic [2:0] st_reg;
   logic [2:0] len_reg;
   logic [6:0] cnt_reg;
   logic [6:0] scnt_reg;
   wire        stb_n = ext_rd_n_reg & ext_wr_n_reg;
   wire        take  = external_move_instruction_start & ~cpu_hold_reg;
   // -----------------------------------------
   // shadow stretch and cycle counters
   // -----------------------------------------
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         st_reg <= 3'h1;
      end else if (sfr_wr && sfr_addr == 8'h8e) begin
         st_reg <= sfr_wdata[2:0];
      end
      len_reg <= take ? st_reg : len_reg;
      cnt_reg <= take ? 7'h01 : cnt_reg + {6'h00, cnt_reg != 7'h7f};
      scnt_reg <= stb_n ? 7'h00 : scnt_reg + 7'h01;
   end
   property p_idle; !cpu_hold_reg |-> stb_n; endproperty
   a_idle: assert property (p_idle) else $error("strobe outside move");
   property p_addr; !stb_n |-> $stable(ext_addr_reg); endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   property p_take; take |=> cpu_hold_reg; endproperty
   a_take: assert property (p_take) else $error("move not taken");
   property p_len; external_move_instruction_done_reg |-> cnt_reg == 4 * len_reg + 9; endproperty
   a_len: assert property (p_len) else $error("move length wrong");
   property p_swid; $rose(stb_n) |-> scnt_reg == (len_reg == 0 ? 2 : 4 * len_reg); endproperty
   a_swid: assert property (p_swid) else $error("strobe width wrong");
   property p_spos; $fell(stb_n) |-> cnt_reg == (len_reg == 0 ? 6 : 7); endproperty
   a_spos: assert property (p_spos) else $error("strobe start wrong");
   property p_ri;
      take && !external_move_instruction_use_ptr |=> ext_addr_reg == {$past(p2_value), $past(ri_value)};
   endproperty
   a_ri: assert property (p_ri) else $error("indirect address wrong");
   property p_sel; $past(sfr_addr) == 8'h86 |-> sfr_rdata_reg[7:1] == 7'h00; endproperty
   a_sel: assert property (p_sel) else $error("select upper bits set");
   property p_ck; $past(sfr_addr) == 8'h8e |-> sfr_rdata_reg[7:3] == 5'h00; endproperty
   a_ck: assert property (p_ck) else $error("clock control upper bits set");
   property p_oe; !ext_wr_n_reg |-> ext_data_oe_reg; endproperty
   a_oe: assert property (p_oe) else $error("write strobe without data drive");
   property p_oe_rd; ext_data_oe_reg |-> cpu_hold_reg && ext_rd_n_reg; endproperty
   a_oe_rd: assert property (p_oe_rd) else $error("data driven outside write");
   c_s0: cover property ($rose(stb_n) && len_reg == 3'h0);
   c_s7: cover property ($rose(stb_n) && len_reg == 3'h7);
   c_ptr: cover property (take && external_move_instruction_use_ptr);
endmodule
bind sxda_top sxda_monitor i_mon (.*);
`default_nettype wire

/* File: sim/sxda_mem_model.sv */
// external data memory model for the move sequencer
`timescale 1ns/1ps
`default_nettype none
module sxda_mem_model (
   input  wire logic        ref_clk, // core clock
   input  wire logic [15:0] addr,    // external address
   input  wire logic [7:0]  wdata,   // bus from device
   input  wire logic        rd_n,    // read strobe
   input  wire logic        wr_n,    // write strobe
   output logic      [7:0]  rdata    // bus to device
);
   logic [7:0] mem [0:255];
   logic [7:0] last_reg = 8'h00;
   // released bus shows the inverse of the last byte, never a held copy
   assign rdata = !rd_n ? mem[addr[7:0]] : ~last_reg;
   always @(posedge ref_clk) begin
      if (!wr_n) mem[addr[7:0]] <= wdata;
      if (!rd_n) last_reg <= rdata;
   end
endmodule
`default_nettype wire

/* File: sim/tb_stretched_ext_data_access.sv */
// self-checking bench for the external move sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
   $display("Error %0t: got %h expected %h", $time, a, e); end end
module tb_stretched_ext_data_access;
   logic        ref_clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sel_inc = 1'b0, sel_dec = 1'b0;
   logic        ptr_load = 1'b0, ptr_inc = 1'b0, external_move_instruction_start = 1'b0;
   logic        external_move_instruction_use_ptr = 1'b0, external_move_instruction_write = 1'b0;
   logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, ri_value = 8'h00;
   logic [7:0]  p2_value = 8'h5a, external_move_instruction_wdata = 8'h00;
   logic [15:0] ptr_load_data = 16'h0000;
   logic [7:0]  ext_data_in, sfr_rdata_reg, ext_data_out_reg, external_move_instruction_rdata_reg;
   logic [15:0] ext_addr_reg;
   logic        ext_data_oe_reg, ext_rd_n_reg, ext_wr_n_reg, cpu_hold_reg, external_move_instruction_done_reg;
   int          n_errors = 0, comparisons = 0, cyc = 0;
   sxda_top i_dut (.*);
   sxda_mem_model i_mem (.ref_clk(ref_clk), .addr(ext_addr_reg), .wdata(ext_data_out_reg),
      .rd_n(ext_rd_n_reg), .wr_n(ext_wr_n_reg), .rdata(ext_data_in));
   initial forever #25 ref_clk = ~ref_clk;
   task automatic end_sim;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic sfr_put(input logic [7:0] a, d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask
   task automatic sfr_chk(input logic [7:0] a, e);
      sfr_addr = a;
      @(negedge ref_clk);
      `CHK(sfr_rdata_reg, e)
   endtask
   task automatic strobe(input logic ld, pi, si, sd, input logic [15:0] v);
      {ptr_load, ptr_inc, sel_inc, sel_dec} = {ld, pi, si, sd};
      ptr_load_data = v;
      @(negedge ref_clk);
      {ptr_load, ptr_inc, sel_inc, sel_dec} = 4'h0;
      @(negedge ref_clk);
   endtask
   // waits out the whole move, so callers may start the next one at once
   task automatic external_move_instruction(input logic up, wr, input logic [7:0] ri, d, input int len,
                       input logic [15:0] ea);
      int n;
      {external_move_instruction_use_ptr, external_move_instruction_write, ri_value, external_move_instruction_wdata} = {up, wr, ri, d};
      external_move_instruction_start = 1'b1;
      @(negedge ref_clk);
      external_move_instruction_start = 1'b0;
      `CHK(ext_addr_reg, ea)
      n = 1;
      while (external_move_instruction_done_reg !== 1'b1 && n < 60) begin
         @(negedge ref_clk);
         n++;
      end
      `CHK(n, len)
      if (!wr) `CHK(external_move_instruction_rdata_reg, d)
      @(negedge ref_clk);
   endtask
   task automatic busy_case;
      sfr_put(8'h8e, 8'h02);
      fork
         external_move_instruction(0, 1, 8'h20, 8'h77, 17, 16'h5a20);
         begin
            repeat (4) @(negedge ref_clk);
            external_move_instruction_start = 1'b1;
            sfr_put(8'h8e, 8'h00);
            external_move_instruction_start = 1'b0;
         end
      join
      `CHK(cpu_hold_reg, 1'b0)
   endtask
   task automatic ptr_case;
      strobe(1, 0, 0, 0, 16'h1234);
      strobe(0, 0, 1, 0, 16'h0000);
      sfr_chk(8'h86, 8'h01);
      strobe(1, 0, 0, 0, 16'h12ab);
      strobe(0, 1, 0, 0, 16'h0000);
      strobe(0, 0, 1, 1, 16'h0000);
      external_move_instruction(1, 1, 8'h00, 8'h99, 9, 16'h12ac);
      strobe(0, 0, 0, 1, 16'h0000);
      external_move_instruction(1, 1, 8'h00, 8'h55, 9, 16'h1234);
      sfr_put(8'h86, 8'hff);
      sfr_chk(8'h86, 8'h01);
      external_move_instruction(1, 0, 8'h00, 8'h99, 9, 16'h12ac);
   endtask
   initial begin
      repeat (20) @(negedge ref_clk);
      sys_rst = 1'b0;
      sfr_chk(8'h8e, 8'h01);
      sfr_chk(8'h86, 8'h00);
      sfr_chk(8'h42, 8'h00);
      external_move_instruction(0, 1, 8'h10, 8'h3c, 13, 16'h5a10);
      for (int s = 0; s < 8; s++) begin
         sfr_put(8'h8e, {5'h1f, s[2:0]});
         sfr_chk(8'h8e, {5'h00, s[2:0]});
         external_move_instruction(0, 1, s[7:0], 8'ha0 + s[7:0], 4 * s + 9, {8'h5a, s[7:0]});
         external_move_instruction(0, 0, s[7:0], 8'ha0 + s[7:0], 4 * s + 9, {8'h5a, s[7:0]});
      end
      busy_case();
      ptr_case();
      end_sim();
   end
endmodule
`default_nettype wire
